// ==== src/ppipe_defines.svh ====
// Constants for the PIPE MAC block: register offsets, field positions, resets, timing.
// Assumes inclusion by its bare name from the design files.
`ifndef PPIPE_DEFINES_SVH
`define PPIPE_DEFINES_SVH

`define PPIPE_OFF_CTRL 12'h000
`define PPIPE_OFF_TEST 12'h004
`define PPIPE_OFF_TXCFG 12'h008
`define PPIPE_OFF_STATUS 12'h00c
`define PPIPE_OFF_RXSTAT 12'h010
`define PPIPE_OFF_LTSSM 12'h014

`define PPIPE_CTRL_ENABLE 0
`define PPIPE_CTRL_SWING 1
`define PPIPE_CTRL_POLARITY 2
`define PPIPE_CTRL_DETECT 3
`define PPIPE_CTRL_IDLE 4
`define PPIPE_CTRL_SKIP 5
`define PPIPE_CTRL_RATE_LO 8
`define PPIPE_CTRL_PWR_LO 12
`define PPIPE_CTRL_MARGIN_LO 16
`define PPIPE_CTRL_EIINF_LO 20

`define PPIPE_CTRL_RESET 32'h0000_0012
`define PPIPE_TEST_RESET 32'h0000_0008
`define PPIPE_TEST_FIXED_MASK 32'hffff_ff1a
`define PPIPE_TEST_FIXED_VAL 32'h0000_0008

`define PPIPE_TEST_SIM 0
`define PPIPE_TEST_DESCR 2
`define PPIPE_TEST_COMPL_DIS 5
`define PPIPE_TEST_COMPL_FORCE 6
`define PPIPE_TEST_LP_DIS 7

`define PPIPE_POLL_TIMEOUT_US 24
`define PPIPE_POLL_TIMEOUT_SIM_US 1
`define PPIPE_CLK_MHZ 25

`endif

// ==== src/ppipe_mac.sv ====
// MAC side of a per-lane PIPE interface with an APB register slave.
// Assumes the PIPE clock arrives as a pin and is sampled by pclk.
//
// Behaviour
// - Drive eight-bit symbol plus control flag
// - Skip low marks transmit data invalid
// - De-emphasis set from partner training indication
// - Detect request starts receiver detection
// - Swing high full, low half
// - Three-bit margin from link control setting
// - Polarity request inverts PHY decoder
// - Two-bit power state request
// - Rate select codes 00, 01, 10
// - Five-bit training state, quiet is zero
// - Three-bit idle inference select
// - Test bit 0 accelerates, flagged on output
// - Test bit 2 disables scrambling
// - Test bits 5,6 steer compliance entry
// - Test bit 7 disables low-power negotiation
// - Symbol path eight bits wide
// - One, two or four lanes striped
`include "ppipe_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module ppipe_mac #(
  parameter int LANES = 1
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Transmit stream from the core
  input wire logic [8*LANES-1:0] core_tx_data,
  input wire logic [LANES-1:0] core_tx_is_control,
  input wire logic partner_deemph,
  // PIPE clock pin
  input wire logic pipe_pclk,
  // PIPE transmit side
  output logic [8*LANES-1:0] tx_symbol_lane,
  output logic [LANES-1:0] tx_symbol_is_control,
  output logic [LANES-1:0] tx_compliance_disparity,
  output logic [LANES-1:0] tx_symbol_valid_skip,
  output logic [LANES-1:0] tx_deemphasis_select,
  output logic [LANES-1:0] tx_receiver_detect_req,
  output logic [LANES-1:0] tx_idle_request,
  output logic tx_swing_full,
  output logic [2:0] tx_margin_select,
  output logic [LANES-1:0] rx_invert_polarity,
  output logic [2*LANES-1:0] phy_power_state_req,
  output logic [1:0] pipe_rate_select,
  output logic [4:0] link_training_state,
  output logic [3*LANES-1:0] idle_inference_select,
  // PIPE receive side
  input wire logic [8*LANES-1:0] rx_symbol_lane,
  input wire logic [LANES-1:0] rx_symbol_is_control,
  input wire logic [LANES-1:0] rx_idle_detected,
  input wire logic [3*LANES-1:0] rx_status_code,
  input wire logic [LANES-1:0] rx_symbol_locked,
  input wire logic [LANES-1:0] phy_request_done,
  // Received stream to the core
  output logic [8*LANES-1:0] core_rx_data,
  output logic [LANES-1:0] core_rx_is_control,
  output logic [LANES-1:0] core_rx_valid,
  // Test side outputs
  output logic accel_init_active,
  output logic scramble_disable,
  output logic lowpower_neg_disable
);
  localparam int TIMEOUT_CYC = `PPIPE_POLL_TIMEOUT_US * `PPIPE_CLK_MHZ;
  localparam int TIMEOUT_SIM_CYC = `PPIPE_POLL_TIMEOUT_SIM_US * `PPIPE_CLK_MHZ;

  if (!(LANES == 1 || LANES == 2 || LANES == 4)) begin : g_lanes_check
    $error("LANES must be 1, 2 or 4");
  end

  // Registers
  logic [31:0] ctrl;
  logic [31:0] test;
  logic tx_deemph_q;
  logic [15:0] timeout_cnt;
  logic compl_dis_prev;
  ppipe_pkg::ppipe_ltssm_e state;
  ppipe_pkg::ppipe_ltssm_e next_state;

  // APB decode
  wire apb_write = psel & penable & pwrite;
  wire apb_read = psel & ~pwrite;
  wire hit_ctrl = paddr == `PPIPE_OFF_CTRL;
  wire hit_test = paddr == `PPIPE_OFF_TEST;
  wire hit_txcfg = paddr == `PPIPE_OFF_TXCFG;
  wire hit_status = paddr == `PPIPE_OFF_STATUS;
  wire hit_rxstat = paddr == `PPIPE_OFF_RXSTAT;
  wire hit_ltssm = paddr == `PPIPE_OFF_LTSSM;
  wire hit_any = hit_ctrl | hit_test | hit_txcfg | hit_status | hit_rxstat | hit_ltssm;
  wire [31:0] test_wval = (pwdata & ~`PPIPE_TEST_FIXED_MASK) | `PPIPE_TEST_FIXED_VAL;
  wire ctrl_enable = ctrl[`PPIPE_CTRL_ENABLE];

  // PIPE clock edge detection through a two-stage synchroniser
  logic pclk_s1;
  logic pclk_s2;
  logic pclk_s3;
  wire pipe_rise = pclk_s2 & ~pclk_s3;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pclk_s1 <= 1'b0;
      pclk_s2 <= 1'b0;
      pclk_s3 <= 1'b0;
    end else begin
      pclk_s1 <= pipe_pclk;
      pclk_s2 <= pclk_s1;
      pclk_s3 <= pclk_s2;
    end
  end

  // Per-lane receive synchronisers and capture at PIPE clock edges
  logic [LANES-1:0] locked_any;
  logic [LANES-1:0] done_any;
  logic [LANES-1:0] idle_any;
  logic [3*LANES-1:0] status_q;
  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : g_lane
      logic [13:0] rx_s1;
      logic [13:0] rx_s2;
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          rx_s1 <= 14'h0000;
          rx_s2 <= 14'h0000;
        end else begin
          rx_s1 <= {rx_symbol_lane[8*g +: 8], rx_symbol_is_control[g], rx_symbol_locked[g],
                    phy_request_done[g], rx_idle_detected[g], rx_status_code[3*g +: 2]};
          rx_s2 <= rx_s1;
        end
      end
      // Top status bit travels separately to keep the bundle at fourteen
      logic st2_s1;
      logic st2_s2;
      logic [7:0] data_q;
      logic ctl_q;
      logic val_q;
      logic [2:0] st_q;
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          st2_s1 <= 1'b0;
          st2_s2 <= 1'b0;
          data_q <= 8'h00;
          ctl_q <= 1'b0;
          val_q <= 1'b0;
          st_q <= 3'h0;
        end else begin
          st2_s1 <= rx_status_code[3*g+2];
          st2_s2 <= st2_s1;
          if (pipe_rise) begin
            data_q <= rx_s2[13:6];
            ctl_q <= rx_s2[5];
            val_q <= rx_s2[4];
            st_q <= {st2_s2, rx_s2[1:0]};
          end
        end
      end
      assign core_rx_data[8*g +: 8] = data_q;
      assign core_rx_is_control[g] = ctl_q;
      assign core_rx_valid[g] = val_q;
      assign status_q[3*g +: 3] = st_q;
      assign locked_any[g] = val_q;
      assign done_any[g] = rx_s2[3];
      assign idle_any[g] = rx_s2[2];
    end
  endgenerate

  // Training state walk
  wire accel = test[`PPIPE_TEST_SIM];
  wire compl_dis = test[`PPIPE_TEST_COMPL_DIS];
  wire compl_toggle = compl_dis ^ compl_dis_prev;
  wire [15:0] timeout_lim = accel ? 16'(TIMEOUT_SIM_CYC) : 16'(TIMEOUT_CYC);
  wire timed_out = timeout_cnt >= timeout_lim;
  wire all_locked = &locked_any;
  wire any_locked = |locked_any;
  wire done_now = |done_any;

  always_comb begin
    next_state = state;
    case (state)
      ppipe_pkg::ppipe_detect_quiet: begin
        if (ctrl_enable) next_state = ppipe_pkg::ppipe_detect_active;
      end
      ppipe_pkg::ppipe_detect_active: begin
        if (done_now) next_state = ppipe_pkg::ppipe_polling_active;
      end
      ppipe_pkg::ppipe_polling_active: begin
        if (all_locked) begin
          next_state = ppipe_pkg::ppipe_polling_config;
        end else if (timed_out && !compl_dis &&
                     (any_locked || test[`PPIPE_TEST_COMPL_FORCE])) begin
          next_state = ppipe_pkg::ppipe_polling_compliance;
        end else if (timed_out) begin
          next_state = ppipe_pkg::ppipe_detect_quiet;
        end
      end
      ppipe_pkg::ppipe_polling_compliance: begin
        if (compl_toggle) next_state = ppipe_pkg::ppipe_polling_active;
      end
      ppipe_pkg::ppipe_polling_config: begin
        if (all_locked) next_state = ppipe_pkg::ppipe_config_complete;
      end
      ppipe_pkg::ppipe_config_complete: next_state = ppipe_pkg::ppipe_l0;
      ppipe_pkg::ppipe_l0: begin
        if (!all_locked) next_state = ppipe_pkg::ppipe_detect_quiet;
        else if (&idle_any && !test[`PPIPE_TEST_LP_DIS]) begin
          next_state = ppipe_pkg::ppipe_l0s;
        end
      end
      ppipe_pkg::ppipe_l0s: begin
        if (!(&idle_any)) next_state = ppipe_pkg::ppipe_l0;
      end
      default: next_state = ppipe_pkg::ppipe_detect_quiet;
    endcase
    if (!ctrl_enable) next_state = ppipe_pkg::ppipe_detect_quiet;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ppipe_pkg::ppipe_detect_quiet;
      timeout_cnt <= 16'h0000;
      compl_dis_prev <= 1'b0;
      tx_deemph_q <= 1'b0;
    end else if (pipe_rise) begin
      state <= next_state;
      compl_dis_prev <= compl_dis;
      timeout_cnt <= (state == next_state && !timed_out) ? timeout_cnt + 16'h0001 : 16'h0000;
      if (state == ppipe_pkg::ppipe_polling_config) tx_deemph_q <= partner_deemph;
    end
  end

  // APB register writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `PPIPE_CTRL_RESET;
      test <= `PPIPE_TEST_RESET;
    end else if (apb_write && hit_ctrl) begin
      ctrl <= pwdata;
    end else if (apb_write && hit_test) begin
      test <= test_wval;
    end
  end

  // APB read mux
  wire [31:0] status_word = {16'h0000, 4'h0, 4'(LANES), 2'h0, |done_any, |idle_any,
                             |locked_any, 1'b0, accel, test[`PPIPE_TEST_DESCR]};
  wire [31:0] read_mux = hit_ctrl ? ctrl :
                         hit_test ? test :
                         hit_txcfg ? {31'h0, tx_deemph_q} :
                         hit_status ? status_word :
                         hit_rxstat ? {{(32-3*LANES){1'b0}}, status_q} :
                         hit_ltssm ? {27'h0, state} : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (apb_read && !penable) begin
      prdata <= read_mux;
    end
  end

  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit_any;

  // PIPE transmit outputs; symbols, detect and idle requests launched on PIPE clock edges, swing and margin from ctrl, power request from ctrl or P0s in L0s
  wire in_compl = state == ppipe_pkg::ppipe_polling_compliance;
  wire in_detect = state == ppipe_pkg::ppipe_detect_active;
  wire idle_state = state == ppipe_pkg::ppipe_detect_quiet || in_detect ||
                    state == ppipe_pkg::ppipe_l0s;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_symbol_lane <= '0;
      tx_symbol_is_control <= '0;
      tx_compliance_disparity <= '0;
      tx_symbol_valid_skip <= '0;
      tx_receiver_detect_req <= '0;
      tx_idle_request <= '1;
    end else if (pipe_rise) begin
      tx_symbol_lane <= core_tx_data;
      tx_symbol_is_control <= core_tx_is_control;
      tx_compliance_disparity <= {LANES{in_compl}};
      tx_symbol_valid_skip <= {LANES{~ctrl[`PPIPE_CTRL_SKIP]}};
      tx_receiver_detect_req <= {LANES{in_detect | ctrl[`PPIPE_CTRL_DETECT]}};
      tx_idle_request <= {LANES{idle_state | ctrl[`PPIPE_CTRL_IDLE]}};
    end
  end

  wire [1:0] pwr_sel = state == ppipe_pkg::ppipe_l0s ? ppipe_pkg::ppipe_p0s :
                       ctrl[`PPIPE_CTRL_PWR_LO +: 2];
  wire [1:0] rate_sel = ctrl[`PPIPE_CTRL_RATE_LO +: 2] == 2'h3 ? 2'h0 :
                        ctrl[`PPIPE_CTRL_RATE_LO +: 2];
  wire [2:0] inf_sel = state == ppipe_pkg::ppipe_l0 ? ctrl[`PPIPE_CTRL_EIINF_LO +: 3] : 3'h0;

  assign tx_deemphasis_select = {LANES{tx_deemph_q}};
  assign tx_swing_full = ctrl[`PPIPE_CTRL_SWING];
  assign tx_margin_select = ctrl[`PPIPE_CTRL_MARGIN_LO +: 3];
  assign rx_invert_polarity = {LANES{ctrl[`PPIPE_CTRL_POLARITY]}};
  assign phy_power_state_req = {LANES{pwr_sel}};
  assign pipe_rate_select = rate_sel;
  assign link_training_state = state;
  assign idle_inference_select = {LANES{inf_sel}};
  assign accel_init_active = accel;
  assign scramble_disable = test[`PPIPE_TEST_DESCR];
  assign lowpower_neg_disable = test[`PPIPE_TEST_LP_DIS];
endmodule : ppipe_mac
`default_nettype wire

// ==== src/ppipe_pkg.sv ====
// Types shared by the PIPE MAC block.
// Assumes nothing beyond a SystemVerilog compiler.
package ppipe_pkg;
  typedef enum logic [4:0] {
    ppipe_detect_quiet = 5'h00,
    ppipe_detect_active = 5'h01,
    ppipe_polling_active = 5'h02,
    ppipe_polling_compliance = 5'h03,
    ppipe_polling_config = 5'h04,
    ppipe_config_complete = 5'h09,
    ppipe_l0 = 5'h0f,
    ppipe_l0s = 5'h14
  } ppipe_ltssm_e;
  typedef enum logic [1:0] {
    ppipe_p0 = 2'h0,
    ppipe_p0s = 2'h1,
    ppipe_p1 = 2'h2,
    ppipe_p2 = 2'h3
  } ppipe_power_e;
endpackage : ppipe_pkg

// ==== test/pcie_pipe_phy_interface_bench.sv ====
// Self-checking bench for the PIPE MAC block over APB.
// Assumes ppipe_mac, ppipe_phy_model and the bound checker.
`timescale 1ns/1ns
`default_nettype none
module pcie_pipe_phy_interface_bench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, lock_en, partner_deemph;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] core_tx_data, tx_symbol_lane, rx_symbol_lane, core_rx_data;
  logic core_tx_is_control, pipe_pclk, tx_symbol_is_control, tx_compliance_disparity;
  logic tx_symbol_valid_skip, tx_deemphasis_select, tx_receiver_detect_req, tx_idle_request;
  logic tx_swing_full, rx_invert_polarity, rx_symbol_is_control, rx_idle_detected;
  logic rx_symbol_locked, phy_request_done, core_rx_is_control, core_rx_valid;
  logic accel_init_active, scramble_disable, lowpower_neg_disable;
  logic [2:0] tx_margin_select, idle_inference_select, rx_status_code;
  logic [1:0] phy_power_state_req, pipe_rate_select;
  logic [4:0] link_training_state;
  int mismatches, checks_done;
  ppipe_mac #(.LANES(1)) u_ppipe_mac (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .core_tx_data, .core_tx_is_control, .partner_deemph,
    .pipe_pclk, .tx_symbol_lane, .tx_symbol_is_control, .tx_compliance_disparity,
    .tx_symbol_valid_skip, .tx_deemphasis_select, .tx_receiver_detect_req, .tx_idle_request,
    .tx_swing_full, .tx_margin_select, .rx_invert_polarity, .phy_power_state_req,
    .pipe_rate_select, .link_training_state, .idle_inference_select, .rx_symbol_lane,
    .rx_symbol_is_control, .rx_idle_detected, .rx_status_code, .rx_symbol_locked,
    .phy_request_done, .core_rx_data, .core_rx_is_control, .core_rx_valid,
    .accel_init_active, .scramble_disable, .lowpower_neg_disable);
  ppipe_phy_model u_ppipe_phy_model (.lock_en, .phy_power_state_req, .tx_receiver_detect_req,
    .pipe_pclk, .rx_symbol_lane, .rx_symbol_is_control, .rx_idle_detected, .rx_status_code,
    .rx_symbol_locked, .phy_request_done);
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  task stop_test;
    if (mismatches == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : stop_test
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // One transfer, then one idle cycle before the next
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      mismatches++;
      stop_test();
    end else begin
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask : apb
  // Returns at the first pclk edge that sees a link clock rise
  task link_align;
    int n;
    n = 0;
    while (pipe_pclk !== 1'b0 && n < 9) begin
      @(posedge pclk);
      n++;
    end
    while (pipe_pclk !== 1'b1 && n < 18) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 18) begin
      mismatches++;
      stop_test();
    end
  endtask : link_align
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, lock_en, partner_deemph} = '0;
    {core_tx_data, core_tx_is_control, mismatches, checks_done} = '0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("idle", 1, tx_idle_request);
    chk("state", 0, link_training_state);
    chk("deemph", 0, tx_deemphasis_select);
    apb(0, 12'h000, 0);
    chk("ctrl", 32'h12, rd);
    apb(0, 12'h004, 0);
    chk("test", 32'h8, rd);
    apb(1, 12'h004, 32'hffff_ffff);
    apb(0, 12'h004, 0);
    chk("test", 32'hed, rd);
    chk("test_out", 3'h7, {accel_init_active, scramble_disable, lowpower_neg_disable});
    apb(1, 12'h004, 0);
    chk("test_out", 3'h0, {accel_init_active, scramble_disable, lowpower_neg_disable});
    apb(0, 12'h020, 32'h0);
    chk("unmapped_data", 0, rd);
    chk("unmapped_err", 1, err);
    for (int i = 0; i < 4; i++) begin
      apb(1, 12'h000, 32'h1 | (32'(i) << 8) | (32'(i) << 12) | (32'(i) << 16));
      chk("rate", i == 3 ? 0 : i, pipe_rate_select);
      chk("power", i, phy_power_state_req);
      chk("margin", i, tx_margin_select);
      chk("swing", 0, tx_swing_full);
    end
    apb(1, 12'h000, 32'h0050_0017);
    chk("inference", 0, idle_inference_select);
    chk("swing", 1, tx_swing_full);
    chk("polarity", 1, rx_invert_polarity);
    core_tx_data <= 8'ha5;
    core_tx_is_control <= 1'b1;
    repeat (24) @(posedge pclk);
    chk("tx_symbol", 8'ha5, tx_symbol_lane);
    chk("tx_control", 1, tx_symbol_is_control);
    chk("skip", 1, tx_symbol_valid_skip);
    chk("idle", 1, tx_idle_request);
    lock_en <= 1'b1;
    partner_deemph <= 1'b1;
    repeat (80) @(posedge pclk);
    chk("rx_valid", 1, core_rx_valid);
    chk("state", 5'h0f, link_training_state);
    chk("deemph", 1, tx_deemphasis_select);
    chk("inference", 3'h5, idle_inference_select);
    link_align();
    repeat (5) @(posedge pclk);
    chk("rx_data", rx_symbol_lane, core_rx_data);
    chk("rx_control", rx_symbol_is_control, core_rx_is_control);
    lock_en <= 1'b0;
    repeat (40) @(posedge pclk);
    chk("rx_valid", 0, core_rx_valid);
    apb(1, 12'h000, 32'h3f);
    repeat (24) @(posedge pclk);
    chk("detect", 1, tx_receiver_detect_req);
    chk("skip", 0, tx_symbol_valid_skip);
    apb(1, 12'h000, 32'h0);
    repeat (16) @(posedge pclk);
    apb(1, 12'h004, 32'h41);
    apb(1, 12'h000, 32'h1);
    repeat (400) @(posedge pclk);
    chk("state", 5'h03, link_training_state);
    chk("compliance", 1, tx_compliance_disparity);
    apb(1, 12'h004, 32'h61);
    repeat (24) @(posedge pclk);
    chk("state", 5'h02, link_training_state);
    chk("compliance", 0, tx_compliance_disparity);
    stop_test();
  end
endmodule : pcie_pipe_phy_interface_bench
`default_nettype wire

// ==== test/ppipe_mac_checker.sv ====
// Port checker for the PIPE MAC block.
// Assumes a bind onto ppipe_mac and an APB slave with no wait states.
`timescale 1ns/1ns
`default_nettype none
module ppipe_mac_checker #(
  parameter int LANES = 1
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pslverr,
  // PIPE and test side
  input wire logic pipe_pclk,
  input wire logic [8*LANES-1:0] tx_symbol_lane,
  input wire logic tx_swing_full,
  input wire logic [2:0] tx_margin_select,
  input wire logic [1:0] pipe_rate_select,
  input wire logic [4:0] link_training_state,
  input wire logic accel_init_active,
  input wire logic scramble_disable,
  input wire logic lowpower_neg_disable
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic acc = psel && penable;
  wire logic wr_ctrl = acc && pwrite && paddr == 12'h000;
  wire logic wr_test = acc && pwrite && paddr == 12'h004;
  property p_err;
    acc && paddr == 12'h020 |-> pslverr;
  endproperty
  a_err: assert property (p_err) else $error("no error on unmapped access");
  property p_rate;
    wr_ctrl |=> pipe_rate_select == ($past(pwdata[9:8]) == 2'h3 ? 2'h0 : $past(pwdata[9:8]));
  endproperty
  a_rate: assert property (p_rate) else $error("rate select wrong");
  property p_swing;
    wr_ctrl |=> tx_swing_full == $past(pwdata[1]);
  endproperty
  a_swing: assert property (p_swing) else $error("swing wrong");
  property p_margin;
    wr_ctrl |=> tx_margin_select == $past(pwdata[18:16]);
  endproperty
  a_margin: assert property (p_margin) else $error("margin wrong");
  property p_accel;
    wr_test |=> accel_init_active == $past(pwdata[0]);
  endproperty
  a_accel: assert property (p_accel) else $error("accel flag wrong");
  property p_descr;
    wr_test |=> scramble_disable == $past(pwdata[2]);
  endproperty
  a_descr: assert property (p_descr) else $error("scramble flag wrong");
  property p_lowpwr;
    wr_test |=> lowpower_neg_disable == $past(pwdata[7]);
  endproperty
  a_lowpwr: assert property (p_lowpwr) else $error("low power flag wrong");
  property p_state;
    link_training_state inside {5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h09, 5'h0f, 5'h14};
  endproperty
  a_state: assert property (p_state) else $error("illegal state code");
  property p_tx;
    $changed(tx_symbol_lane) |-> $past(pipe_pclk, 3) || $past(pipe_pclk, 4) || $past(pipe_pclk, 5);
  endproperty
  a_tx: assert property (p_tx) else $error("symbol changed off link clock");
endmodule : ppipe_mac_checker
bind ppipe_mac ppipe_mac_checker #(.LANES(LANES)) u_ppipe_mac_checker (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .pslverr, .pipe_pclk, .tx_symbol_lane, .tx_swing_full,
  .tx_margin_select, .pipe_rate_select, .link_training_state, .accel_init_active,
  .scramble_disable, .lowpower_neg_disable);
`default_nettype wire

// ==== test/ppipe_phy_model.sv ====
// Behavioural PHY for one lane: free-running link clock and receive stream.
// Assumes the bench steers symbol lock through lock_en.
`timescale 1ns/1ns
`default_nettype none
module ppipe_phy_model (
  // Bench control
  input wire logic lock_en,
  // Requests from the MAC
  input wire logic [1:0] phy_power_state_req,
  input wire logic tx_receiver_detect_req,
  // Answers to the MAC
  output logic pipe_pclk,
  output logic [7:0] rx_symbol_lane,
  output logic rx_symbol_is_control,
  output logic rx_idle_detected,
  output logic [2:0] rx_status_code,
  output logic rx_symbol_locked,
  output logic phy_request_done
);
  logic [1:0] last_power;
  initial begin
    {rx_symbol_lane, rx_symbol_is_control, rx_idle_detected} = 10'h001;
    {rx_status_code, rx_symbol_locked, phy_request_done, last_power} = 7'h00;
    pipe_pclk = 1'b0;
    #7;
    forever #160 pipe_pclk = ~pipe_pclk;
  end
  // Data keeps moving even unlocked, so stale values never look valid
  always @(posedge pipe_pclk) begin
    rx_symbol_lane <= rx_symbol_lane + 8'h01;
    rx_symbol_is_control <= rx_symbol_lane[1:0] == 2'h3;
    rx_symbol_locked <= lock_en;
    rx_idle_detected <= !lock_en;
    rx_status_code <= tx_receiver_detect_req ? 3'h3 : 3'h0;
    phy_request_done <= phy_power_state_req != last_power || tx_receiver_detect_req;
    last_power <= phy_power_state_req;
  end
endmodule : ppipe_phy_model
`default_nettype wire
